// ==== fes_pkg.sv ====
// Package: register offsets, erase patterns, field layout and timing
// constants shared by the flash controller and its processor-side end.
// Assumes an 8-bit special-function register space.
package fes_pkg;
   // ==========================================================
   // Register offsets (special-function register addresses)
   localparam logic [7:0] FES_ADDR_ERASE_CMD = 8'h94;
   localparam logic [7:0] FES_ADDR_MEEN = 8'hB2;
   localparam logic [7:0] FES_ADDR_PAGE_SEL = 8'hB7;
   localparam logic [7:0] FES_ADDR_CTRL = 8'hB3;
   localparam logic [7:0] FES_ADDR_STATUS = 8'hB4;
   localparam logic [7:0] FES_ADDR_BANK = 8'hB5;
   localparam int FES_MEEN_BIT = 1;
   localparam int FES_PAGE_LSB = 1;
   localparam int FES_CTRL_PWE_BIT = 0;
   localparam int FES_CTRL_LOCK_BIT = 1;
   // ==========================================================
   // Erase patterns and data values
   localparam logic [7:0] FES_PAT_MASS = 8'hAA;
   localparam logic [7:0] FES_PAT_PAGE = 8'h55;
   localparam logic [7:0] FES_ERASED = 8'hFF;
   // ==========================================================
   // Geometry and timing
   localparam int FES_PAGE_BYTES = 1024;
   localparam int FES_PAGE_AW = 10;
   localparam int FES_WINDOW_AW = 15;
   localparam int FES_EARLY_BOOT_FLAG_CYCLES = 60;
   localparam int FES_CLK_HZ = 10000000;
   localparam int FES_ERASE_MS = 20;
   localparam int FES_ERASE_CYCLES = FES_CLK_HZ / 1000 * FES_ERASE_MS;
   localparam int FES_WRITE_US = 42;
   localparam int FES_WRITE_CYCLES = (FES_CLK_HZ / 1000000) * FES_WRITE_US;
   localparam logic [7:0] FES_RESET_BYTE = 8'h00;
   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {FES_IDLE, FES_MASS, FES_PAGE, FES_WRITE} fes_state_t;
endpackage

// ==== fes_if.sv ====
// Interface joining the processor-side end to the flash controller.
// Assumes both ends run on the one ref_clk.
`timescale 1ns/1ps
interface fes_if;
   logic regWr;         // Register write strobe
   logic regRd;         // Register read strobe
   logic [7:0] regAddr; // Register address
   logic [7:0] regWdata;// Register write data
   logic [7:0] regRdata;// Register read data
   logic regAck;        // Access answered
   logic codeRd;        // Code fetch request
   logic [15:0] codeAddr; // Code address
   logic [7:0] codeData;  // Code fetch data
   logic codeAck;         // Code fetch answered
   logic dataWr;          // External data store
   logic [15:0] dataAddr; // Store address
   logic [7:0] dataWdata; // Store data
   logic intEnabled;      // Processor interrupts are enabled
   logic engineBusy;      // Compute engine fetching code
   modport dev (input regWr, regRd, regAddr, regWdata, codeRd, codeAddr,
      dataWr, dataAddr, dataWdata, intEnabled, engineBusy,
      output regRdata, regAck, codeData, codeAck);
   modport cpu (output regWr, regRd, regAddr, regWdata, codeRd, codeAddr,
      dataWr, dataAddr, dataWdata, intEnabled, engineBusy,
      input regRdata, regAck, codeData, codeAck);
endinterface

// ==== fes_cpu_end.sv ====
// Processor-side end: turns classic Wishbone accesses into register
// strobes and forwards code fetches and data stores unchanged.
// Assumes one access at a time from the Wishbone master.
`timescale 1ns/1ps
module fes_cpu_end (
   input wire logic ref_clk,        // System clock
   input wire logic arst_n,         // Async reset, active low
   fes_if.cpu bus,                  // Link to the flash controller
   input wire logic wbCyc,          // Wishbone cycle
   input wire logic wbStb,          // Wishbone strobe
   input wire logic wbWe,           // Wishbone write
   input wire logic [7:0] wbAdr,    // Wishbone address
   input wire logic [7:0] wbDatIn,  // Wishbone write data
   input wire logic wbSel,          // Wishbone byte select
   output logic [7:0] wbDatOut,     // Wishbone read data
   output logic wbAck,              // Wishbone acknowledge
   input wire logic fetchReq,       // Code fetch request
   input wire logic [15:0] fetchAddr, // Code fetch address
   output logic [7:0] fetchData,    // Fetched byte
   output logic fetchAck,           // Fetch done
   input wire logic storeReq,       // Data store request
   input wire logic [15:0] storeAddr, // Store address
   input wire logic [7:0] storeData,  // Store data
   input wire logic irqOn,          // Interrupts enabled
   input wire logic ceBusy          // Compute engine busy
);
   import fes_pkg::*;
   logic pending;
   logic issued;
   // ==========================================================
   // Request issue: one strobe per Wishbone access
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         issued <= 1'b0;
      end else if (wbAck) begin
         issued <= 1'b0;
      end else if (pending && !issued) begin
         issued <= 1'b1;
      end
   end
   assign pending = wbCyc && wbStb && !wbAck;
   assign bus.regWr = pending && !issued && wbWe && wbSel;
   // A write with its byte lane off goes out as a read, so it is still
   // answered and the master never hangs
   assign bus.regRd = pending && !issued && !(wbWe && wbSel);
   assign bus.regAddr = wbAdr;
   assign bus.regWdata = wbDatIn;
   assign bus.codeRd = fetchReq;
   assign bus.codeAddr = fetchAddr;
   assign bus.dataWr = storeReq;
   assign bus.dataAddr = storeAddr;
   assign bus.dataWdata = storeData;
   assign bus.intEnabled = irqOn;
   assign bus.engineBusy = ceBusy;
   // ==========================================================
   // Answers registered so outputs come from flip-flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wbAck <= 1'b0;
         wbDatOut <= FES_RESET_BYTE;
      end else begin
         wbAck <= bus.regAck && !wbAck;
         if (bus.regAck) begin
            wbDatOut <= bus.regRdata;
         end
      end
   end
   // Fetch answers registered; the ack follows the request level
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fetchAck <= 1'b0;
         fetchData <= FES_RESET_BYTE;
      end else begin
         fetchAck <= bus.codeAck;
         if (bus.codeAck) begin
            fetchData <= bus.codeData;
         end
      end
   end
endmodule

// ==== fes_flash_ctrl.sv ====
// Flash controller: erase sequencer, byte programming, upper-window
// bank mapping, code-protect lock and early-boot emulator inhibit.
// Assumes single-clock operation and a behavioural flash array inside.
// Operation
// - Erased bytes read 0xFF; rewrite needs erase.
// - No single-byte erase; whole page only.
// - Mass erase: enable bit, then 0xAA.
// - Mass erase refused unless emulator enabled.
// - Page erase: page number, then 0x55.
// - Firmware avoids brownout during page erase.
// - Low window fixed; upper window banked.
// - Four banks: value 00 aliases lower.
// - Eight banks: upper starts at n*32KB.
// - Lock blocks emulator except global erase.
// - Emulator inhibited 60 cycles; flag shown.
// - After early boot emulator may take over.
// - Lock clears on reset, set-only.
// - Lock cleared only by erase plus reset; code clears it on any reset.
// - Lock prevents external code reads.
// - Lock ignores page-zero page erase.
// - Lock inhibits byte writes to page zero.
// - Firmware sets lock during early boot.
// - Pages are 1024 bytes each.
// - Write enable routes stores; ignored with irq.
// - Write while engine busy fails, irq raised.
`timescale 1ns/1ps
module fes_flash_ctrl #(
   parameter int BANK_BITS = 3,                 // 2 or 3 bank-select bits
   parameter int ERASE_CYCLES = fes_pkg::FES_ERASE_CYCLES // Erase time
) (
   input wire logic ref_clk,          // System clock
   input wire logic arst_n,           // Async reset, active low
   fes_if.dev bus,                    // Processor link
   input wire logic emuEnableReq,     // Emulator asks to be enabled
   input wire logic emuRd,            // Emulator code read request
   input wire logic [15:0] emuAddr,   // Emulator read address
   input wire logic emuPageErase,     // Emulator page erase request
   input wire logic emuMassErase,     // Emulator global erase request
   input wire logic emuWr,            // Emulator byte write request
   input wire logic [7:0] emuWdata,   // Emulator write data
   output logic [7:0] emuRdata,       // Emulator read data
   output logic emuEnabled,           // Emulator port enabled
   output logic emuCtrlCpu,           // Emulator may control processor
   output logic earlyBoot,            // Early-boot flag
   output logic lockState,            // Code-protect lock state
   output logic eraseBusy,            // Erase or write in progress
   output logic writeCollisionIrq     // One-cycle collision pulse
);
   import fes_pkg::*;
   localparam int MEM_AW = FES_WINDOW_AW + BANK_BITS;
   localparam int MEM_BYTES = 1 << MEM_AW;
   localparam int PAGES = MEM_BYTES / FES_PAGE_BYTES;
   localparam int PGW = MEM_AW - FES_PAGE_AW;
   logic [7:0] flashMem [MEM_BYTES];
   fes_state_t state_reg, state_next;
   logic [31:0] timer_reg;
   logic [7:0] pageSel_reg;
   logic massEnable_reg;
   logic writeEnable_reg;
   logic codeProtectLock_reg;
   logic [BANK_BITS-1:0] bank_reg;
   logic [6:0] bootCnt_reg;
   logic [PGW-1:0] erasePage_reg;
   logic [MEM_AW-1:0] wrAddr_reg;
   logic [7:0] wrData_reg;
   logic [MEM_AW-1:0] cpuPhys, emuPhys, storePhys;
   logic cmdWr, startMass, startPage, startWrite, emuLive;
   // ==========================================================
   // Bank mapping: low window fixed, upper window bank-selected
   function automatic logic [MEM_AW-1:0] mapAddr(input logic [15:0] a,
      input logic [BANK_BITS-1:0] b);
      logic [BANK_BITS-1:0] sel;
      sel = a[15] ? b : '0;
      mapAddr = {sel, a[FES_WINDOW_AW-1:0]};
   endfunction
   assign cpuPhys = mapAddr(bus.codeAddr, bank_reg);
   assign emuPhys = mapAddr(emuAddr, bank_reg);
   assign storePhys = mapAddr(bus.dataAddr, bank_reg);
   // ==========================================================
   // Early boot: emulator held off for the first cycles after reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bootCnt_reg <= '0;
      end else if (bootCnt_reg != 7'(FES_EARLY_BOOT_FLAG_CYCLES)) begin
         bootCnt_reg <= bootCnt_reg + 7'd1;
      end
   end
   // Enable only after early boot; lock then leaves just global erase
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         earlyBoot <= 1'b1;
         emuEnabled <= 1'b0;
         emuCtrlCpu <= 1'b0;
      end else begin
         earlyBoot <= (bootCnt_reg < 7'(FES_EARLY_BOOT_FLAG_CYCLES - 1));
         emuEnabled <= emuEnableReq && !earlyBoot;
         emuCtrlCpu <= emuEnableReq && !earlyBoot && !codeProtectLock_reg;
      end
   end
   assign emuLive = emuEnabled && !earlyBoot;
   // ==========================================================
   // Register writes
   assign cmdWr = bus.regWr && (bus.regAddr == FES_ADDR_ERASE_CMD);
   // Lock is set-only; reset is the only clear, hence erase then reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         codeProtectLock_reg <= 1'b0;
      end else if (bus.regWr && bus.regAddr == FES_ADDR_CTRL &&
            bus.regWdata[FES_CTRL_LOCK_BIT]) begin
         codeProtectLock_reg <= 1'b1;
      end
   end
   // Write enable ignored while interrupts on; held until the next CTRL write
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         writeEnable_reg <= 1'b0;
      end else if (bus.regWr && bus.regAddr == FES_ADDR_CTRL &&
            !bus.intEnabled) begin
         writeEnable_reg <= bus.regWdata[FES_CTRL_PWE_BIT];
      end
   end
   // Plain configuration registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pageSel_reg <= FES_RESET_BYTE;
         massEnable_reg <= 1'b0;
         bank_reg <= '0;
      end else begin
         if (bus.regWr && bus.regAddr == FES_ADDR_PAGE_SEL) begin
            pageSel_reg <= bus.regWdata;
         end
         if (bus.regWr && bus.regAddr == FES_ADDR_MEEN) begin
            massEnable_reg <= bus.regWdata[FES_MEEN_BIT];
         end else if (startMass) begin
            massEnable_reg <= 1'b0;
         end
         if (bus.regWr && bus.regAddr == FES_ADDR_BANK) begin
            bank_reg <= bus.regWdata[BANK_BITS-1:0];
         end
      end
   end
   // ==========================================================
   // Start conditions
   assign startMass = (state_reg == FES_IDLE) && emuLive &&
      ((cmdWr && bus.regWdata == FES_PAT_MASS && massEnable_reg) ||
       emuMassErase);
   assign startPage = (state_reg == FES_IDLE) && !startMass &&
      ((cmdWr && bus.regWdata == FES_PAT_PAGE) ||
       (emuPageErase && emuLive && !codeProtectLock_reg)) &&
      !(codeProtectLock_reg && pageSel_reg[7:FES_PAGE_LSB] == 7'd0);
   assign startWrite = (state_reg == FES_IDLE) && !startMass && !startPage &&
      ((bus.dataWr && writeEnable_reg) ||
       (emuWr && emuLive && !codeProtectLock_reg)) &&
      !bus.engineBusy &&
      !(codeProtectLock_reg && storePhys[MEM_AW-1:FES_PAGE_AW] == '0);
   // Collision pulse when a store meets a busy engine
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         writeCollisionIrq <= 1'b0;
      end else begin
         writeCollisionIrq <= bus.dataWr && writeEnable_reg &&
            bus.engineBusy;
      end
   end
   // ==========================================================
   // Sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         FES_IDLE: begin
            if (startMass) begin
               state_next = FES_MASS;
            end else if (startPage) begin
               state_next = FES_PAGE;
            end else if (startWrite) begin
               state_next = FES_WRITE;
            end
         end
         default: begin
            if (timer_reg == 32'd0) begin
               state_next = FES_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= FES_IDLE;
         timer_reg <= '0;
         erasePage_reg <= '0;
         wrAddr_reg <= '0;
         wrData_reg <= FES_RESET_BYTE;
      end else begin
         state_reg <= state_next;
         if (startMass || startPage) begin
            timer_reg <= 32'(ERASE_CYCLES - 1);
            erasePage_reg <= PGW'(pageSel_reg[7:FES_PAGE_LSB]);
         end else if (startWrite) begin
            timer_reg <= 32'(FES_WRITE_CYCLES - 1);
            wrAddr_reg <= (bus.dataWr && writeEnable_reg) ? storePhys :
               emuPhys;
            wrData_reg <= (bus.dataWr && writeEnable_reg) ? bus.dataWdata :
               emuWdata;
         end else if (timer_reg != 32'd0) begin
            timer_reg <= timer_reg - 32'd1;
         end
      end
   end
   // Array update at the end of each operation; programming only clears
   // bits, so a rewrite without erase cannot raise a zero back to one
   always_ff @(posedge ref_clk) begin
      if (state_reg != FES_IDLE && timer_reg == 32'd0) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            if (state_reg == FES_MASS ||
                  (state_reg == FES_PAGE &&
                   PGW'(i / FES_PAGE_BYTES) == erasePage_reg)) begin
               flashMem[i] <= FES_ERASED;
            end
         end
         if (state_reg == FES_WRITE) begin
            flashMem[wrAddr_reg] <= flashMem[wrAddr_reg] & wrData_reg;
         end
      end
   end
   // ==========================================================
   // Read paths
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.regAck <= 1'b0;
         bus.regRdata <= FES_RESET_BYTE;
         bus.codeAck <= 1'b0;
         bus.codeData <= FES_RESET_BYTE;
         emuRdata <= FES_RESET_BYTE;
         lockState <= 1'b0;
         eraseBusy <= 1'b0;
      end else begin
         bus.regAck <= bus.regWr || bus.regRd;
         if (bus.regAddr == FES_ADDR_PAGE_SEL) begin
            bus.regRdata <= pageSel_reg;
         end else if (bus.regAddr == FES_ADDR_MEEN) begin
            bus.regRdata <= {6'd0, massEnable_reg, 1'b0};
         end else if (bus.regAddr == FES_ADDR_CTRL) begin
            bus.regRdata <= {6'd0, codeProtectLock_reg, writeEnable_reg};
         end else if (bus.regAddr == FES_ADDR_STATUS) begin
            bus.regRdata <= {5'd0, emuEnabled, state_reg != FES_IDLE,
               earlyBoot};
         end else if (bus.regAddr == FES_ADDR_BANK) begin
            bus.regRdata <= 8'(bank_reg);
         end else begin
            bus.regRdata <= FES_RESET_BYTE;
         end
         bus.codeAck <= bus.codeRd;
         bus.codeData <= flashMem[cpuPhys];
         if (emuRd && emuLive && !codeProtectLock_reg) begin
            emuRdata <= flashMem[emuPhys];
         end else begin
            emuRdata <= FES_RESET_BYTE;
         end
         lockState <= codeProtectLock_reg;
         eraseBusy <= state_next != FES_IDLE;
      end
   end
endmodule

// ==== fes_asserts.sv ====
// Checker for the link between the processor end and the flash controller.
// Assumes one clock and the link's signals wired in as plain inputs.
`timescale 1ns/1ps
module fes_asserts
   import fes_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic arst_n, // Async reset, active low
   input wire logic regWr, // Register write strobe
   input wire logic regRd, // Register read strobe
   input wire logic [7:0] regAddr, // Register address
   input wire logic [7:0] regWdata, // Register write data
   input wire logic [7:0] regRdata, // Register read data
   input wire logic regAck, // Access answered
   input wire logic codeRd, // Code fetch request
   input wire logic codeAck // Code fetch answered
);
   logic [6:0] bootCnt;
   logic statRd;
   // ==========================================================
   // Helpers
   // Cycles since reset release; saturates so late reads stay judged
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) bootCnt <= 7'h00;
      else if (bootCnt != 7'h7F) bootCnt <= bootCnt + 7'h01;
   end
   // Status reads, with margins round the early-boot edge
   assign statRd = regRd && (regAddr == FES_ADDR_STATUS);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // Assertions
   a_reg_ack_next: assert property (
      (regWr || regRd) |=> regAck) else $error("strobe not answered");
   a_ack_has_cause: assert property (
      regAck |-> $past(regWr || regRd)) else $error("ack without strobe");
   a_ack_one_cycle: assert property (
      regAck |=> !regAck) else $error("ack longer than one cycle");
   a_strobe_single: assert property (
      (regWr || regRd) |=> !(regWr || regRd) [*3])
      else $error("strobe repeated within one access");
   a_strobe_exclusive: assert property (
      !(regWr && regRd)) else $error("read and write strobes together");
   a_boot_flag_set: assert property (
      statRd && (bootCnt < 7'h32) |=> regRdata[0])
      else $error("early-boot flag low too soon");
   a_boot_flag_clear: assert property (
      statRd && (bootCnt > 7'h46) |=> !regRdata[0])
      else $error("early-boot flag still high");
   a_unmapped_zero: assert property (
      regRd && (regAddr == 8'h00) |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_fetch_answered: assert property (
      $rose(codeRd) |-> ##[1:3] codeAck) else $error("fetch not answered");
   // Main scenarios reached
   cover property (regWr && regAddr == FES_ADDR_ERASE_CMD
      && regWdata == FES_PAT_MASS);
   cover property (regWr && regAddr == FES_ADDR_ERASE_CMD
      && regWdata == FES_PAT_PAGE);
   cover property (statRd && bootCnt > 7'h46);
endmodule

// ==== testbench.sv ====
// Testbench: both ends joined by the link, driven over Wishbone,
// code fetch, data store and emulator pins. Assumes a 10 MHz clock.
`timescale 1ns/1ps
module testbench;
   import fes_pkg::*;
   logic ref_clk, arst_n, wbCyc, wbStb, wbWe, wbSel, wbAck, fetchReq;
   logic fetchAck, storeReq, irqOn, ceBusy, emuEnableReq, emuRd, emuWr;
   logic emuPageErase, emuMassErase, emuEnabled, emuCtrlCpu, earlyBoot;
   logic lockState, eraseBusy, writeCollisionIrq;
   logic [7:0] wbAdr, wbDatIn, wbDatOut, fetchData, storeData, q;
   logic [7:0] emuWdata, emuRdata;
   logic [15:0] fetchAddr, storeAddr, emuAddr;
   logic [7:0] pats [3] = '{8'h5A, 8'hAA, 8'h00};
   int miscompares, num_checks, irqCnt;
   // ==========================================================
   // Design and link; erase time cut to 20 cycles to keep runs short
   fes_if link();
   fes_cpu_end i_fes_cpu_end(.ref_clk, .arst_n, .bus(link), .wbCyc, .wbStb,
      .wbWe, .wbAdr, .wbDatIn, .wbSel, .wbDatOut, .wbAck, .fetchReq,
      .fetchAddr, .fetchData, .fetchAck, .storeReq, .storeAddr, .storeData,
      .irqOn, .ceBusy);
   fes_flash_ctrl #(.BANK_BITS(3), .ERASE_CYCLES(20)) i_fes_flash_ctrl(
      .ref_clk, .arst_n, .bus(link), .emuEnableReq, .emuRd, .emuAddr,
      .emuPageErase, .emuMassErase, .emuWr, .emuWdata, .emuRdata,
      .emuEnabled, .emuCtrlCpu, .earlyBoot, .lockState, .eraseBusy,
      .writeCollisionIrq);
   fes_asserts i_fes_asserts(.ref_clk, .arst_n, .regWr(link.regWr),
      .regRd(link.regRd), .regAddr(link.regAddr), .regWdata(link.regWdata),
      .regRdata(link.regRdata), .regAck(link.regAck),
      .codeRd(link.codeRd), .codeAck(link.codeAck));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // ==========================================================
   // Access tasks
   task automatic wrap_up();
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Mode 0 register read, 1 register write, 2 code fetch; q gets data
   task automatic acc(input int m, input logic [15:0] a, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      if (m == 2) begin
         fetchReq <= 1'b1;
         fetchAddr <= a;
      end else begin
         wbCyc <= 1'b1;
         wbStb <= 1'b1;
         wbWe <= (m == 1);
         wbAdr <= a[7:0];
         wbDatIn <= d;
      end
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while ((m == 2 ? fetchAck : wbAck) !== 1'b1 && n < 400);
      if (n >= 400) begin
         miscompares++;
         wrap_up();
      end
      q = (m == 2) ? fetchData : wbDatOut;
      fetchReq <= 1'b0;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      // Fetch ack trails the request by two edges; let it drain
      if (m == 2) repeat (2) @(posedge ref_clk);
   endtask
   // Poll the busy bit; a stuck busy ends the run
   task automatic idle();
      int n;
      n = 0;
      do begin
         acc(0, FES_ADDR_STATUS, 8'h00);
         n++;
      end while (q[1] !== 1'b0 && n < 400);
      if (n >= 400) begin
         miscompares++;
         wrap_up();
      end
   endtask
   // One store pulse; collision pulses counted in the cycles after it
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      storeReq <= 1'b1;
      storeAddr <= a;
      storeData <= d;
      @(posedge ref_clk);
      storeReq <= 1'b0;
      repeat (3) begin
         @(posedge ref_clk);
         if (writeCollisionIrq === 1'b1) irqCnt++;
      end
      idle();
   endtask
   task automatic store(input logic [15:0] a, input logic [7:0] d);
      acc(1, FES_ADDR_CTRL, 8'h01);
      put(a, d);
      acc(1, FES_ADDR_CTRL, 8'h00);
   endtask
   // Emulator read has no handshake, so data is taken after 3 edges
   task automatic emu(input logic [15:0] a);
      @(posedge ref_clk);
      emuRd <= 1'b1;
      emuAddr <= a;
      repeat (3) @(posedge ref_clk);
      q = emuRdata;
      emuRd <= 1'b0;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      {arst_n, wbCyc, wbStb, wbWe, fetchReq, storeReq, irqOn} = '0;
      {ceBusy, emuEnableReq, emuRd, emuWr, emuPageErase, emuMassErase} = '0;
      {wbAdr, wbDatIn, storeData, emuWdata} = '0;
      {fetchAddr, storeAddr, emuAddr} = '0;
      wbSel = 1'b1;
      {miscompares, num_checks, irqCnt} = '0;
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      emuEnableReq <= 1'b1;
      acc(0, FES_ADDR_STATUS, 8'h00);
      chk(q & 8'h05, 8'h01);
      chk({7'h00, earlyBoot}, 8'h01);
      emuEnableReq <= 1'b0;
      repeat (70) @(posedge ref_clk);
      acc(0, FES_ADDR_STATUS, 8'h00);
      chk(q & 8'h05, 8'h00);
      chk({7'h00, earlyBoot}, 8'h00);
      acc(0, 8'h00, 8'h00);
      chk(q, 8'h00);
      acc(1, FES_ADDR_MEEN, 8'h02);
      acc(1, FES_ADDR_ERASE_CMD, FES_PAT_MASS);
      acc(0, FES_ADDR_STATUS, 8'h00);
      chk(q & 8'h02, 8'h00);
      emuEnableReq <= 1'b1;
      acc(0, FES_ADDR_STATUS, 8'h00);
      chk(q & 8'h04, 8'h04);
      chk({7'h00, emuEnabled}, 8'h01);
      chk({7'h00, emuCtrlCpu}, 8'h01);
      acc(1, FES_ADDR_MEEN, 8'h02);
      acc(1, FES_ADDR_ERASE_CMD, FES_PAT_MASS);
      acc(0, FES_ADDR_STATUS, 8'h00);
      chk(q & 8'h02, 8'h02);
      chk({7'h00, eraseBusy}, 8'h01);
      idle();
      acc(2, 16'h0000, 8'h00);
      chk(q, FES_ERASED);
      acc(2, 16'h7FFF, 8'h00);
      chk(q, FES_ERASED);
      // Wrong patterns, and the mass pattern once the arm bit has gone
      for (int i = 0; i < 3; i++) begin
         acc(1, FES_ADDR_ERASE_CMD, pats[i]);
         acc(0, FES_ADDR_STATUS, 8'h00);
         chk(q & 8'h02, 8'h00);
      end
      store(16'h0400, 8'h3C);
      store(16'h07FF, 8'h11);
      store(16'h0800, 8'h22);
      store(16'h0010, 8'h5A);
      acc(2, 16'h0400, 8'h00);
      chk(q, 8'h3C);
      store(16'h0400, 8'hC3);
      acc(2, 16'h0400, 8'h00);
      chk(q, 8'h00);
      acc(1, FES_ADDR_PAGE_SEL, 8'h02);
      acc(1, FES_ADDR_ERASE_CMD, FES_PAT_PAGE);
      idle();
      acc(2, 16'h0400, 8'h00);
      chk(q, FES_ERASED);
      acc(2, 16'h07FF, 8'h00);
      chk(q, FES_ERASED);
      acc(2, 16'h0800, 8'h00);
      chk(q, 8'h22);
      irqOn <= 1'b1;
      acc(1, FES_ADDR_CTRL, 8'h01);
      irqOn <= 1'b0;
      put(16'h0500, 8'h00);
      acc(2, 16'h0500, 8'h00);
      chk(q, FES_ERASED);
      acc(1, FES_ADDR_CTRL, 8'h01);
      ceBusy <= 1'b1;
      put(16'h0600, 8'h00);
      ceBusy <= 1'b0;
      acc(1, FES_ADDR_CTRL, 8'h00);
      chk(irqCnt[7:0], 8'h01);
      acc(2, 16'h0600, 8'h00);
      chk(q, FES_ERASED);
      acc(1, FES_ADDR_BANK, 8'h02);
      store(16'h8000, 8'h77);
      acc(1, FES_ADDR_BANK, 8'h01);
      acc(2, 16'h8000, 8'h00);
      chk(q, FES_ERASED);
      acc(1, FES_ADDR_BANK, 8'h02);
      acc(2, 16'h8000, 8'h00);
      chk(q, 8'h77);
      acc(2, 16'h0010, 8'h00);
      chk(q, 8'h5A);
      acc(1, FES_ADDR_BANK, 8'h00);
      acc(2, 16'h8800, 8'h00);
      chk(q, 8'h22);
      emu(16'h0800);
      chk(q, 8'h22);
      // Emulator byte write while the lock is still clear
      emuAddr <= 16'h0900;
      emuWdata <= 8'h66;
      emuWr <= 1'b1;
      @(posedge ref_clk);
      emuWr <= 1'b0;
      idle();
      acc(2, 16'h0900, 8'h00);
      chk(q, 8'h66);
      acc(1, FES_ADDR_CTRL, 8'h02);
      chk({7'h00, emuCtrlCpu}, 8'h00);
      chk({7'h00, lockState}, 8'h01);
      acc(1, FES_ADDR_CTRL, 8'h00);
      chk({7'h00, lockState}, 8'h01);
      emu(16'h0800);
      chk(q, 8'h00);
      acc(1, FES_ADDR_PAGE_SEL, 8'h00);
      acc(1, FES_ADDR_ERASE_CMD, FES_PAT_PAGE);
      @(posedge ref_clk);
      emuPageErase <= 1'b1;
      @(posedge ref_clk);
      emuPageErase <= 1'b0;
      acc(0, FES_ADDR_STATUS, 8'h00);
      chk(q & 8'h02, 8'h00);
      store(16'h0011, 8'h00);
      acc(2, 16'h0011, 8'h00);
      chk(q, FES_ERASED);
      acc(2, 16'h0010, 8'h00);
      chk(q, 8'h5A);
      @(posedge ref_clk);
      emuMassErase <= 1'b1;
      @(posedge ref_clk);
      emuMassErase <= 1'b0;
      idle();
      acc(2, 16'h0010, 8'h00);
      chk(q, FES_ERASED);
      chk({7'h00, lockState}, 8'h01);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      chk({7'h00, lockState}, 8'h00);
      acc(1, FES_ADDR_CTRL, 8'h02);
      chk({7'h00, lockState}, 8'h01);
      wrap_up();
   end
endmodule
